// [lvd_ctrl.sv]
// Low-voltage detect control and status logic, one clock domain.
// Assumes comparator output is asynchronous and that chipReset reports
// every chip-wide reset with its cause from outside the block.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns

// Contract
// - In reset mode, hold internal reset while supply below level.
// - A detector reset sets reset-cause bit 0.
// - Both registers clear on any reset except the detector's own.
// - Control bit 7 enables the comparator.
// - Control bit 1 selects interrupt (0) or reset (1) response.
// - Control bit 0 is read-only low-supply flag, 0 when disabled.
// - Interrupt line carries flag only when enabled and mode is 0; a latched pending edge stays on it after disable or a mode change.
// - Control register accepts single-bit and whole-byte writes.
// - Level select bits 3..0 pick one of ten levels, code 0 highest.
// - Changing level while enabled is undefined; disable first.
// - Setting mode bit with adequate supply gives no reset.
// - Any reset sets the interrupt mask flag.
// - Logic keeps running with the CPU clock stopped.
// - Reset-cause clears on pin reset, power-on clear, or a read.
module lvd_ctrl
	import lvd_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire lvd_bus_s   bus,
	input  wire logic       compBelow,
	input  wire logic       chipReset,
	input  wire logic       resetByPin,
	output logic [7:0]      rdata,
	output logic [3:0]      levelCode,
	output logic            comparatorEnable,
	output logic            undervoltageIrq,
	output logic            detectorReset
);

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic       enable_q;
	logic       mode_q;
	logic [3:0] level_q;
	logic       cause_q;
	logic       pending_q;
	logic       mask_q;
	logic [2:0] syncBelow_q;
	logic       below_q;
	logic       irqPrev_q;
	logic       ownReset_q;
	logic       softReset;

	logic wrCtrl;
	logic wrLevel;
	logic wrIrq;
	logic rdCause;
	logic irqLevel;
	logic flag;

	assign wrCtrl  = bus.wr && bus.addr == OFF_CONTROL;
	assign wrLevel = bus.wr && bus.addr == OFF_LEVEL && !bus.bitWrite;
	assign wrIrq   = bus.wr && bus.addr == OFF_IRQ_STATUS;
	assign rdCause = bus.rd && bus.addr == OFF_RESET_CAUSE;

	// Chip reset that the detector did not raise clears the registers
	assign softReset = chipReset && !ownReset_q;

	// ---------------------------------------------------------------
	// Comparator synchroniser
	// ---------------------------------------------------------------
	// Runs on the free system clock so standby cannot freeze it
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			syncBelow_q <= 3'h0;
			below_q     <= 1'b0;
		end else begin
			syncBelow_q <= {syncBelow_q[1:0], compBelow};
			if (syncBelow_q[2] == syncBelow_q[1]) begin
				below_q <= syncBelow_q[2];
			end
		end
	end

	assign flag     = enable_q && below_q;
	assign irqLevel = flag && !mode_q;

	// ---------------------------------------------------------------
	// Control register
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			enable_q <= RST_CONTROL[BIT_ENABLE];
			mode_q   <= RST_CONTROL[BIT_MODE];
		end else if (softReset) begin
			enable_q <= RST_CONTROL[BIT_ENABLE];
			mode_q   <= RST_CONTROL[BIT_MODE];
		end else if (wrCtrl) begin
			// Bit writes touch only the selected lane
			if (!bus.bitWrite || bus.bitSel[BIT_ENABLE]) begin
				enable_q <= bus.wdata[BIT_ENABLE];
			end
			if (!bus.bitWrite || bus.bitSel[BIT_MODE]) begin
				mode_q <= bus.wdata[BIT_MODE];
			end
		end
	end

	// ---------------------------------------------------------------
	// Level select register
	// ---------------------------------------------------------------
	// Codes above nine are held as written; the analog side treats them as
	// prohibited. A write while enabled is simply taken, as the level is
	// undefined then anyway.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			level_q <= RST_LEVEL[3:0];
		end else if (softReset) begin
			level_q <= RST_LEVEL[3:0];
		end else if (wrLevel) begin
			level_q <= bus.wdata[3:0];
		end
	end

	// ---------------------------------------------------------------
	// Reset output and cause flag
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			detectorReset <= 1'b0;
			ownReset_q    <= 1'b0;
		end else begin
			// Follows the flag, so adequate supply never resets
			detectorReset <= enable_q && mode_q && below_q;
			ownReset_q    <= enable_q && mode_q && below_q;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cause_q <= 1'b0;
		end else if (enable_q && mode_q && below_q) begin
			cause_q <= 1'b1;
		end else if (resetByPin || rdCause) begin
			cause_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Interrupt pending and mask flags
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irqPrev_q <= 1'b0;
			pending_q <= 1'b0;
			mask_q    <= 1'b1;
		end else begin
			irqPrev_q <= irqLevel;
			if (chipReset) begin
				mask_q    <= 1'b1;
				pending_q <= 1'b0;
			end else begin
				if (irqLevel && !irqPrev_q) begin
					pending_q <= 1'b1;
				end else if (wrIrq && !bus.wdata[BIT_PENDING]) begin
					pending_q <= 1'b0;
				end
				if (wrIrq) begin
					mask_q <= bus.wdata[BIT_MASK];
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Outputs and read port
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			undervoltageIrq  <= 1'b0;
			comparatorEnable <= 1'b0;
			levelCode        <= RST_LEVEL[3:0];
		end else begin
			undervoltageIrq  <= pending_q && !mask_q;
			comparatorEnable <= enable_q;
			levelCode        <= level_q;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdata <= 8'h00;
		end else if (bus.rd) begin
			case (bus.addr)
				OFF_CONTROL:     rdata <= {enable_q, 5'h00, mode_q, flag};
				OFF_LEVEL:       rdata <= {4'h0, level_q};
				OFF_RESET_CAUSE: rdata <= {7'h00, cause_q};
				OFF_IRQ_STATUS:  rdata <= {6'h00, mask_q, pending_q};
				default:         rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	sequence lowInResetMode;
		enable_q && mode_q && below_q;
	endsequence

	AST_RESET_FOLLOWS: assert property (@(posedge mclk) disable iff (rst)
		lowInResetMode |=> detectorReset)
		else $error("Reset output missed low supply");
	AST_CAUSE_SET: assert property (@(posedge mclk) disable iff (rst)
		lowInResetMode |=> cause_q)
		else $error("Cause flag not set");
	AST_NO_RESET_OK: assert property (@(posedge mclk) disable iff (rst)
		!below_q |=> !detectorReset)
		else $error("Reset with adequate supply");
	AST_FLAG_OFF: assert property (@(posedge mclk) disable iff (rst)
		!enable_q |-> !flag)
		else $error("Flag set while disabled");
	AST_IRQ_MODE: assert property (@(posedge mclk) disable iff (rst)
		mode_q |=> ##1 !undervoltageIrq || $past(pending_q, 2))
		else $error("Interrupt in reset mode");
	AST_MASK_SET: assert property (@(posedge mclk) disable iff (rst)
		chipReset |=> mask_q)
		else $error("Mask not set by reset");
	AST_KEEP_OWN: assert property (@(posedge mclk) disable iff (rst)
		chipReset && ownReset_q && !wrLevel |=> $stable(level_q))
		else $error("Level lost on own reset");
	AST_CAUSE_READ: assert property (@(posedge mclk) disable iff (rst)
		rdCause && !lowInResetMode |=> !cause_q)
		else $error("Cause not cleared by read");
	AST_PIN_CLEAR: assert property (@(posedge mclk) disable iff (rst)
		resetByPin && !lowInResetMode |=> !cause_q)
		else $error("Cause not cleared by pin reset");
	AST_CAUSE_HOLD: assert property (@(posedge mclk) disable iff (rst)
		cause_q && !resetByPin && !rdCause |=> cause_q)
		else $error("Cause flag lost without a clear");

	// ---------------------------------------------------------------
	// Checks: comparator path to the reset output
	// ---------------------------------------------------------------
	// Measured from the synchroniser, not from below_q, so a dropped
	// stage or a broken agreement filter shows up here
	sequence lowAtLastStages;
		enable_q && mode_q && syncBelow_q[2] && syncBelow_q[1] ##1 enable_q && mode_q;
	endsequence

	sequence supplyBackAtLastStages;
		!syncBelow_q[2] && !syncBelow_q[1];
	endsequence

	AST_LOW_REACHES: assert property (@(posedge mclk) disable iff (rst)
		lowAtLastStages |=> detectorReset)
		else $error("Reset output late after low supply");
	AST_HIGH_RELEASES: assert property (@(posedge mclk) disable iff (rst)
		supplyBackAtLastStages |=> ##1 !detectorReset)
		else $error("Reset output held after supply recovered");
	AST_SYNC_AGREE: assert property (@(posedge mclk) disable iff (rst)
		syncBelow_q[2] != syncBelow_q[1] |=> $stable(below_q))
		else $error("Comparator level taken before stages agreed");

	// ---------------------------------------------------------------
	// Checks: register port
	// ---------------------------------------------------------------
	// Writes reach the analog-facing outputs two edges later
	AST_ENABLE_OUT: assert property (@(posedge mclk) disable iff (rst)
		wrCtrl && !bus.bitWrite && !softReset |=>
		##1 comparatorEnable == $past(bus.wdata[BIT_ENABLE], 2))
		else $error("Enable output does not follow byte write");
	AST_LEVEL_OUT: assert property (@(posedge mclk) disable iff (rst)
		wrLevel && !softReset |=> ##1 levelCode == $past(bus.wdata[3:0], 2))
		else $error("Level output does not follow write");
	AST_BIT_LANE: assert property (@(posedge mclk) disable iff (rst)
		wrCtrl && bus.bitWrite && !bus.bitSel[BIT_ENABLE] && !softReset
		|=> $stable(enable_q))
		else $error("Bit write touched the enable lane");
	AST_SOFT_CLEAR: assert property (@(posedge mclk) disable iff (rst)
		softReset |=> enable_q == RST_CONTROL[BIT_ENABLE] && mode_q == RST_CONTROL[BIT_MODE]
		&& level_q == RST_LEVEL[3:0])
		else $error("Registers kept over a foreign reset");
	AST_FLAG_READ: assert property (@(posedge mclk) disable iff (rst)
		bus.rd && bus.addr == OFF_CONTROL && !enable_q |=> !rdata[BIT_FLAG])
		else $error("Flag reads high while disabled");

	// ---------------------------------------------------------------
	// Checks: interrupt path
	// ---------------------------------------------------------------
	// Pending latches edges only, so a low level held under the mask is
	// not replayed when software unmasks later
	AST_PEND_SET: assert property (@(posedge mclk) disable iff (rst)
		irqLevel && !irqPrev_q && !chipReset |=> pending_q)
		else $error("Pending missed a new low-supply edge");
	AST_RESET_QUIET: assert property (@(posedge mclk) disable iff (rst)
		mode_q && !pending_q |=> !pending_q)
		else $error("Pending raised in reset mode");

endmodule : lvd_ctrl

// [lvd_pkg.sv]
// Package for the low-voltage detect control block: offsets, fields, resets.
// Assumes an 8-bit register port and a single 125 MHz system clock.
package lvd_pkg;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [15:0] OFF_CONTROL     = 16'hff50;
	localparam logic [15:0] OFF_LEVEL       = 16'hff51;
	localparam logic [15:0] OFF_RESET_CAUSE = 16'hff52;
	localparam logic [15:0] OFF_IRQ_STATUS  = 16'hff53;

	// ---------------------------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------------------------
	localparam int          BIT_ENABLE     = 7;
	localparam int          BIT_MODE       = 1;
	localparam int          BIT_FLAG       = 0;
	localparam int          BIT_CAUSE      = 0;
	localparam int          BIT_PENDING    = 0;
	localparam int          BIT_MASK       = 1;
	localparam int          LEVEL_W        = 4;
	localparam logic [3:0]  LEVEL_MAX      = 4'h9;
	localparam logic [7:0]  RST_CONTROL    = 8'h00;
	localparam logic [7:0]  RST_LEVEL      = 8'h00;

	// Comparator settling time, for software reference
	localparam real         SETTLE_MS      = 0.2;
	localparam int          CLK_MHZ        = 125;
	localparam int          SETTLE_CYCLES  = int'(SETTLE_MS * 1000.0 * CLK_MHZ);

	// Bus access: bit writes carry a one-hot lane select
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic [7:0]  bitSel;
		logic        bitWrite;
		logic        wr;
		logic        rd;
	} lvd_bus_s;

endpackage : lvd_pkg

// [lvd_ctrl_tb_top.sv]
// Self-checking bench for the low-voltage detect control block.
// Assumes the design carries its own inline assertions; the bench drives
// the register port, comparator and chip-reset inputs directly.
`timescale 1ns/1ns

`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
	$display("[FAIL] %0t got %h expected %h", $time, got, exp); end end

module lvd_ctrl_tb_top
	import lvd_pkg::*;
;
	logic       mclk;
	logic       rst;
	logic       compBelow;
	logic       chipReset;
	logic       resetByPin;
	lvd_bus_s   bus;
	logic [7:0] rdata;
	logic [3:0] levelCode;
	logic       comparatorEnable;
	logic       undervoltageIrq;
	logic       detectorReset;
	logic [7:0] expQ[$];
	logic [7:0] expV;
	logic       rdLast;
	logic [3:0] code;
	int         err_count;
	int         n_compared;
	int         seed;

	lvd_ctrl dut (.mclk(mclk), .rst(rst), .bus(bus), .compBelow(compBelow),
		.chipReset(chipReset), .resetByPin(resetByPin), .rdata(rdata),
		.levelCode(levelCode), .comparatorEnable(comparatorEnable),
		.undervoltageIrq(undervoltageIrq), .detectorReset(detectorReset));

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// ---------------------------------------------------------------
	// Bus tasks and verdict
	// ---------------------------------------------------------------
	task automatic stop_test();
		$display("Compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : stop_test

	// Strobe for one cycle, then idle, so two calls never touch the bus at one edge
	task automatic access(input logic [15:0] a, input logic [7:0] d, input logic [7:0] sel,
		input logic w);
		@(posedge mclk);
		bus <= '{addr: a, wdata: d, bitSel: sel, bitWrite: (sel != 8'h00), wr: w, rd: !w};
		@(posedge mclk);
		bus <= '0;
	endtask : access

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		access(a, d, 8'h00, 1'b1);
	endtask : wr

	task automatic bitWr(input logic [15:0] a, input int pos, input logic v);
		access(a, v ? 8'hff : 8'h00, 8'h01 << pos, 1'b1);
	endtask : bitWr

	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		expQ.push_back(e);
		access(a, 8'h00, 8'h00, 1'b0);
	endtask : rd

	// Synchroniser latency is a few edges, so waits are bounded loops
	task automatic waitSig(input int sel, input logic v);
		int i;
		for (i = 0; i < 50; i++) begin
			@(negedge mclk);
			if ((sel == 0 ? detectorReset : undervoltageIrq) === v) break;
		end
		`CHK((sel == 0 ? detectorReset : undervoltageIrq), v)
		if (i == 50) stop_test();
		// Leave on a rising edge so the next stimulus lands there
		@(posedge mclk);
	endtask : waitSig

	// ---------------------------------------------------------------
	// Read-data monitor: oldest note against the cycle after the read
	// ---------------------------------------------------------------
	always @(posedge mclk) rdLast <= bus.rd;

	always @(negedge mclk) begin
		if (rdLast === 1'b1) begin
			expV = expQ.pop_front();
			`CHK(rdata, expV)
		end
	end

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	initial begin
		rst = 1'b1;
		bus = '0;
		compBelow = 1'b0;
		chipReset = 1'b0;
		resetByPin = 1'b0;
		seed = 57;
		err_count = 0;
		n_compared = 0;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		rd(OFF_CONTROL, RST_CONTROL);
		rd(OFF_LEVEL, RST_LEVEL);
		rd(OFF_IRQ_STATUS, 8'h02);
		rd(16'hff60, 8'h00);
		for (int i = 0; i < 13; i++) begin
			code = (i < 10) ? i[3:0] : 4'($unsigned($random(seed)) % 10);
			wr(OFF_LEVEL, {4'h0, code});
			repeat (2) @(negedge mclk);
			`CHK(levelCode, code)
			rd(OFF_LEVEL, {4'h0, code});
		end
		// Interrupt response: enable, settle, confirm, unmask, then low supply
		wr(OFF_CONTROL, 8'h80);
		repeat (2) @(negedge mclk);
		`CHK(comparatorEnable, 1'b1)
		repeat (SETTLE_CYCLES) @(posedge mclk);
		rd(OFF_CONTROL, 8'h80);
		wr(OFF_IRQ_STATUS, 8'h00);
		compBelow <= 1'b1;
		waitSig(1, 1'b1);
		rd(OFF_CONTROL, 8'h81);
		rd(OFF_IRQ_STATUS, 8'h01);
		wr(OFF_IRQ_STATUS, 8'h03);
		waitSig(1, 1'b0);
		rd(OFF_IRQ_STATUS, 8'h03);
		compBelow <= 1'b0;
		repeat (8) @(posedge mclk);
		rd(OFF_CONTROL, 8'h80);
		wr(OFF_IRQ_STATUS, 8'h02);
		rd(OFF_IRQ_STATUS, 8'h02);
		// Reset response: stop, new level, enable, settle, then mode by bit write
		wr(OFF_CONTROL, 8'h00);
		repeat (2) @(negedge mclk);
		`CHK(comparatorEnable, 1'b0)
		wr(OFF_LEVEL, 8'h05);
		wr(OFF_CONTROL, 8'h80);
		repeat (SETTLE_CYCLES) @(posedge mclk);
		rd(OFF_CONTROL, 8'h80);
		bitWr(OFF_CONTROL, BIT_MODE, 1'b1);
		rd(OFF_CONTROL, 8'h82);
		repeat (10) @(posedge mclk);
		`CHK(detectorReset, 1'b0)
		compBelow <= 1'b1;
		waitSig(0, 1'b1);
		`CHK(undervoltageIrq, 1'b0)
		chipReset <= 1'b1;
		repeat (3) @(posedge mclk);
		chipReset <= 1'b0;
		compBelow <= 1'b0;
		waitSig(0, 1'b0);
		repeat (2) @(posedge mclk);
		rd(OFF_CONTROL, 8'h82);
		rd(OFF_LEVEL, 8'h05);
		rd(OFF_RESET_CAUSE, 8'h01);
		rd(OFF_RESET_CAUSE, 8'h00);
		rd(OFF_IRQ_STATUS, 8'h02);
		// Detector fires again; pin reset then clears cause and both registers
		compBelow <= 1'b1;
		waitSig(0, 1'b1);
		compBelow <= 1'b0;
		waitSig(0, 1'b0);
		chipReset <= 1'b1;
		resetByPin <= 1'b1;
		@(posedge mclk);
		chipReset <= 1'b0;
		resetByPin <= 1'b0;
		compBelow <= 1'b1;
		rd(OFF_RESET_CAUSE, 8'h00);
		rd(OFF_LEVEL, 8'h00);
		repeat (8) @(posedge mclk);
		rd(OFF_CONTROL, 8'h00);
		`CHK(detectorReset, 1'b0)
		repeat (4) @(posedge mclk);
		stop_test();
	end
endmodule : lvd_ctrl_tb_top
